/* File: core/sbt_params.svh */
// Purpose: Constants of the memory boundary-scan port
// Assumes: Included by its bare name from every core file
// Notes: Widths are fixed by the scan register sizes
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

`define SBT_IR_W 3
`define SBT_ID_W 32
`define SBT_BSR_LEN 109
`define SBT_PIN_W 108
`define SBT_OE_CELL 108

`define SBT_OP_EXTEST 3'h0
`define SBT_OP_IDCODE 3'h1
`define SBT_OP_SAMPLEZ 3'h2
`define SBT_OP_SAMPLE 3'h4
`define SBT_OP_BYPASS 3'h7

`define SBT_IR_CAPTURE 3'h1
`define SBT_ID_PRESENT 1'h1

`define SBT_REV_W 3
`define SBT_DEV_W 17
`define SBT_VEND_W 11

`endif

/* File: core/sbt_pkg.sv */
// Purpose: Types shared by the boundary-scan port files
// Assumes: sbt_params.svh supplies the widths
// Notes: Controller states follow the usual sixteen-state walk
`default_nettype none
`include "sbt_params.svh"
package sbt_pkg;
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } sbt_state_e;

   typedef struct packed {
      logic override;
      logic qEnable;
      logic [`SBT_PIN_W-1:0] pattern;
   } sbt_ctl_s;
endpackage
`default_nettype wire

/* File: core/sbt_tap_fsm.sv */
// Purpose: Test controller state machine, stepped by the mode select line
// Assumes: Runs on the test clock; mode select is in that clock's domain
// Notes: Reset lands in the test-logic-reset state
`default_nettype none
`include "sbt_params.svh"
module sbt_tap_fsm
   import sbt_pkg::*;
(
   input wire logic tck,
   input wire logic arst_n,
   input wire logic tms,
   output sbt_state_e state
);
   sbt_state_e state_r;
   sbt_state_e state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: state_nxt = tms ? ST_RESET : ST_IDLE;
         ST_IDLE: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_nxt = tms ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
         default: state_nxt = ST_RESET;
      endcase
   end

   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign state = state_r;
endmodule
`default_nettype wire

/* File: core/sbt_tap.sv */
// Purpose: Boundary-scan test port of a synchronous memory, scan side and pin side
// Assumes: Scan logic on tck, pin logic on core_clk, both reset by arst_n
// Notes: Pin snapshots cross by a toggle handshake; output control crosses by a toggle with no echo
//
// How it works
// [RULE1] With code 001 the fixed identity word is captured and shifted between tdi and tdo.
// [RULE2] With code 000 pins are captured and the preloaded pattern drives the memory outputs.
// [RULE3] With code 010 pins are captured, the chain is shifted and all outputs float.
// [RULE4] With code 100 pins are captured and the chain is shifted, memory running as usual.
// [RULE5] With code 111 a single bypass stage sits between tdi and tdo.
// [RULE6] The controller never loads codes 011, 101 or 110; they select bypass here.
// [RULE7] The identity word holds revision 31:29, device type 28:12, vendor 11:1 and a one in 0.
// [RULE8] tdo changes only on a falling test clock edge.
// [RULE9] Chain cell 108 enables the data outputs in code 000 and is preset to one on reset.
// [RULE10] Reset and the test-logic-reset state both select the identity code.
// [RULE11] A shifted instruction takes effect only in the update state.
// [RULE12] The chain shifts from its top cell at tdi down to cell 0 at tdo.
// [RULE13] Instruction 3, bypass 1, identity 32 and chain 109 bits each shift once per clock.
`default_nettype none
`include "sbt_params.svh"
module sbt_tap
   import sbt_pkg::*;
#(
   parameter logic [`SBT_REV_W-1:0] REVISION = 3'h0,
   // Arbitrary neutral value
   parameter logic [`SBT_DEV_W-1:0] DEVICE_CODE = 17'h00abc,
   // Arbitrary neutral value
   parameter logic [`SBT_VEND_W-1:0] VENDOR_CODE = 11'h055
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdoOe,
   input wire logic [`SBT_PIN_W-1:0] pinIn,
   output logic [`SBT_PIN_W-1:0] pinPattern,
   output logic pinOverride,
   output logic qDriveEn
);
   sbt_state_e state;
   logic [`SBT_IR_W-1:0] irShift_r;
   logic [`SBT_IR_W-1:0] ir_r;
   logic bypass_r;
   logic [`SBT_ID_W-1:0] idShift_r;
   logic [`SBT_BSR_LEN-1:0] bsrShift_r;
   logic [`SBT_BSR_LEN-1:0] bsrUpd_r;
   logic [`SBT_PIN_W-1:0] pinCopy_r;
   logic snapSync1_r, snapSync2_r, snapSync3_r, snapAck_r;
   logic ctlTgl_r, wasReset_r;
   logic tdo_r, tdoOe_r;
   logic selBsr, selId, tdoNxt;
   logic [`SBT_ID_W-1:0] idWord;
   localparam logic [`SBT_BSR_LEN-1:0] BSR_PRESET = `SBT_BSR_LEN'(1) << `SBT_OE_CELL;

   // Core-domain signals, with the test-clock control word ctlTck
   logic [`SBT_PIN_W-1:0] pinSync1_r, pinSync2_r, snapReg_r;
   logic snapTgl_r, ackSync1_r, ackSync2_r;
   logic ctlSync1_r, ctlSync2_r, ctlSync3_r;
   sbt_ctl_s ctlTck, ctlCore_r;

   sbt_tap_fsm uFsm (
      .tck(tck),
      .arst_n(arst_n),
      .tms(tms),
      .state(state)
   );

   assign idWord = {REVISION, DEVICE_CODE, VENDOR_CODE, `SBT_ID_PRESENT}; // see [RULE7]
   assign selBsr = (ir_r == `SBT_OP_EXTEST) || (ir_r == `SBT_OP_SAMPLEZ)
                   || (ir_r == `SBT_OP_SAMPLE);
   assign selId = (ir_r == `SBT_OP_IDCODE);

   // Instruction register
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         irShift_r <= `SBT_IR_CAPTURE;
         ir_r <= `SBT_OP_IDCODE; // see [RULE10]
      end else begin
         case (state)
            ST_RESET: ir_r <= `SBT_OP_IDCODE; // see [RULE10]
            ST_CAP_IR: irShift_r <= `SBT_IR_CAPTURE;
            ST_SH_IR: irShift_r <= {tdi, irShift_r[`SBT_IR_W-1:1]}; // see [RULE13]
            ST_UPD_IR: ir_r <= irShift_r; // see [RULE11]
            default: ir_r <= ir_r;
         endcase
      end
   end

   // Bypass stage; reserved codes fall here as well
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         bypass_r <= 1'b0;
      end else if (state == ST_CAP_DR) begin
         bypass_r <= 1'b0;
      end else if (state == ST_SH_DR) begin
         bypass_r <= tdi; // see [RULE5] [RULE6] [RULE13]
      end
   end

   // Identity register
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         idShift_r <= '0;
      end else if (selId && state == ST_CAP_DR) begin
         idShift_r <= idWord; // see [RULE1]
      end else if (selId && state == ST_SH_DR) begin
         idShift_r <= {tdi, idShift_r[`SBT_ID_W-1:1]}; // see [RULE1] [RULE13]
      end
   end

   // Boundary chain; the internal cell captures its own held value
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         bsrShift_r <= BSR_PRESET;
      end else if (selBsr && state == ST_CAP_DR) begin
         bsrShift_r <= {bsrUpd_r[`SBT_OE_CELL], pinCopy_r}; // see [RULE2] [RULE3] [RULE4]
      end else if (selBsr && state == ST_SH_DR) begin
         bsrShift_r <= {tdi, bsrShift_r[`SBT_BSR_LEN-1:1]}; // see [RULE12] [RULE13]
      end
   end

   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         bsrUpd_r <= BSR_PRESET; // see [RULE9]
      end else if (state == ST_RESET) begin
         bsrUpd_r <= BSR_PRESET; // see [RULE9]
      end else if (selBsr && state == ST_UPD_DR) begin
         bsrUpd_r <= bsrShift_r;
      end
   end

   // Serial out, launched on the falling edge so the controller samples it on the rise
   always_comb begin
      tdoNxt = bypass_r;
      if (state == ST_SH_IR) begin
         tdoNxt = irShift_r[0];
      end else if (selBsr) begin
         tdoNxt = bsrShift_r[0];
      end else if (selId) begin
         tdoNxt = idShift_r[0];
      end
   end

   always_ff @(negedge tck or negedge arst_n) begin
      if (!arst_n) begin
         tdo_r <= 1'b0;
         tdoOe_r <= 1'b0;
      end else begin
         tdo_r <= tdoNxt; // see [RULE8]
         tdoOe_r <= (state == ST_SH_IR) || (state == ST_SH_DR); // see [RULE8]
      end
   end

   assign tdo = tdo_r;
   assign tdoOe = tdoOe_r;

   // Pin snapshot arrives from the core side; the echo frees the next one
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         snapSync1_r <= 1'b0;
         snapSync2_r <= 1'b0;
         snapSync3_r <= 1'b0;
         snapAck_r <= 1'b0;
         pinCopy_r <= '0;
      end else begin
         snapSync1_r <= snapTgl_r;
         snapSync2_r <= snapSync1_r;
         snapSync3_r <= snapSync2_r;
         if (snapSync2_r != snapSync3_r) begin
            pinCopy_r <= snapReg_r;
            snapAck_r <= ~snapAck_r;
         end
      end
   end

   // Output control is only republished after an update or a fresh controller reset
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         ctlTgl_r <= 1'b0;
         wasReset_r <= 1'b1;
      end else begin
         wasReset_r <= (state == ST_RESET);
         if (state == ST_UPD_IR || state == ST_UPD_DR || (state == ST_RESET && !wasReset_r)) begin
            ctlTgl_r <= ~ctlTgl_r;
         end
      end
   end

   always_comb begin
      ctlTck.override = (ir_r == `SBT_OP_EXTEST); // see [RULE2]
      ctlTck.pattern = bsrUpd_r[`SBT_PIN_W-1:0]; // see [RULE2]
      ctlTck.qEnable = 1'b1; // see [RULE1] [RULE4] [RULE5]
      if (ir_r == `SBT_OP_SAMPLEZ) begin
         ctlTck.qEnable = 1'b0; // see [RULE3]
      end else if (ir_r == `SBT_OP_EXTEST) begin
         ctlTck.qEnable = bsrUpd_r[`SBT_OE_CELL]; // see [RULE9]
      end
   end

   // Core side: pins pass two flops, then a snapshot is offered once the last one is taken
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinSync1_r <= '0;
         pinSync2_r <= '0;
      end else begin
         pinSync1_r <= pinIn;
         pinSync2_r <= pinSync1_r;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ackSync1_r <= 1'b0;
         ackSync2_r <= 1'b0;
         snapReg_r <= '0;
         snapTgl_r <= 1'b0;
      end else begin
         ackSync1_r <= snapAck_r;
         ackSync2_r <= ackSync1_r;
         if (ackSync2_r == snapTgl_r) begin
            snapReg_r <= pinSync2_r;
            snapTgl_r <= ~snapTgl_r;
         end
      end
   end

   // Control word is steady for many test clocks after its toggle, so it is copied whole
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctlSync1_r <= 1'b0;
         ctlSync2_r <= 1'b0;
         ctlSync3_r <= 1'b0;
         ctlCore_r <= '{override: 1'b0, qEnable: 1'b1, pattern: '0};
      end else begin
         ctlSync1_r <= ctlTgl_r;
         ctlSync2_r <= ctlSync1_r;
         ctlSync3_r <= ctlSync2_r;
         if (ctlSync2_r != ctlSync3_r) begin
            ctlCore_r <= ctlTck;
         end
      end
   end

   assign pinPattern = ctlCore_r.pattern;
   assign pinOverride = ctlCore_r.override;
   assign qDriveEn = ctlCore_r.qEnable;
endmodule
`default_nettype wire

/* File: dv/sbt_tap_assertions.sv */
// Purpose: Port-level checks of the boundary-scan test port
// Assumes: Test clock stops low between frames
// Notes: Scan state is judged from tdoOe and tms alone
`default_nettype none
`include "sbt_params.svh"
module sbt_tap_assertions
   import sbt_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdoOe,
   input wire logic [`SBT_PIN_W-1:0] pinPattern,
   input wire logic pinOverride,
   input wire logic qDriveEn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tdoRise_r;
   logic oeRise_r;
   logic tckSeen_r;
   logic [3:0] quiet_r;
   always_ff @(posedge tck or negedge arst_n) begin
      if (!arst_n) begin
         tdoRise_r <= 1'b0;
         oeRise_r <= 1'b0;
      end else begin
         tdoRise_r <= tdo;
         oeRise_r <= tdoOe;
      end
   end
   // Core cycles since the test clock last moved; pins may only follow its activity
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tckSeen_r <= 1'b0;
         quiet_r <= 4'hf;
      end else begin
         tckSeen_r <= tck;
         quiet_r <= (tck != tckSeen_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
      end
   end
   a_tdo_fall_only: assert property (
      @(negedge tck) disable iff (!arst_n) tdo == tdoRise_r)
      else $error("tdo moved while the test clock was high");
   a_oe_fall_only: assert property (
      @(negedge tck) disable iff (!arst_n) tdoOe == oeRise_r)
      else $error("tdoOe moved while the test clock was high");
   a_reset_pin_state: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      $rose(arst_n) |-> !pinOverride && qDriveEn && pinPattern == '0 && !tdoOe && !tdo)
      else $error("pin control not at its reset state");
   a_shift_entry: assert property (
      @(negedge tck) disable iff (!arst_n) $rose(tdoOe) |-> !$past(tms))
      else $error("shift entered with mode select high");
   a_shift_exit: assert property (
      @(negedge tck) disable iff (!arst_n) $fell(tdoOe) |-> $past(tms))
      else $error("shift left with mode select low");
   a_shift_hold: assert property (
      @(negedge tck) disable iff (!arst_n) tdoOe && !tms |=> tdoOe)
      else $error("shift ended while mode select stayed low");
   a_pin_after_update: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      $changed(pinOverride) || $changed(qDriveEn) || $changed(pinPattern) |-> quiet_r < 4'h8)
      else $error("pin control changed with no test clock activity");
   a_override_stands: assert property (
      @(posedge core_clk) disable iff (!arst_n) $rose(pinOverride) |-> pinOverride [*8])
      else $error("pin override dropped right after rising");
endmodule
bind sbt_tap sbt_tap_assertions u_chk (.core_clk(core_clk), .arst_n(arst_n), .tck(tck),
   .tms(tms), .tdo(tdo), .tdoOe(tdoOe), .pinPattern(pinPattern),
   .pinOverride(pinOverride), .qDriveEn(qDriveEn));
`default_nettype wire

/* File: dv/sbt_jtag_ctl.sv */
// Purpose: Boundary-scan test controller model on the test pins
// Assumes: Test clock period 30 ns, stopped low between frames
// Notes: Frames start and end in Run-Test/Idle
`default_nettype none
module sbt_jtag_ctl (
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // New values well after the fall, tdo taken at the rise
   task automatic step(input logic m, input logic d, output logic o);
      #7 tms = m;
      tdi = d;
      #8 o = tdo;
      tck = 1'b1;
      #15 tck = 1'b0;
   endtask
   task automatic go_reset();
      logic o;
      // Odd offset keeps test clock edges clear of the core clock edges
      #3.3;
      repeat (5) step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
   endtask
   // Only documented codes are loaded; results apply through the update state
   task automatic scan(input logic ir, input int n, input logic [108:0] din,
         output logic [108:0] dout);
      logic o;
      #3.3;
      dout = '0;
      step(1'b1, ~tdi, o);
      if (ir) step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
      step(1'b0, ~tdi, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
   endtask
endmodule
`default_nettype wire

/* File: dv/sram_boundary_scan_tap_test.sv */
// Purpose: Self-checking bench of the boundary-scan test port
// Assumes: Core clock 20 ns, test clock from the controller model
// Notes: Pin control is judged 8 core cycles after a reset or an update
`default_nettype none
`include "sbt_params.svh"
module sram_boundary_scan_tap_test
   import sbt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary identity values
   localparam logic [2:0] REV = 3'h5;
   localparam logic [16:0] DEV = 17'h0a5c3;
   localparam logic [10:0] VEND = 11'h2b1;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic tck, tms, tdi, tdo, tdoOe, pinOverride, qDriveEn;
   logic [`SBT_PIN_W-1:0] pinIn = '0;
   logic [`SBT_PIN_W-1:0] pinPattern;
   logic [108:0] dout;
   int mismatches = 0;
   int n_checks = 0;
   always #10 core_clk = ~core_clk;
   sbt_tap #(.REVISION(REV), .DEVICE_CODE(DEV), .VENDOR_CODE(VEND)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdoOe(tdoOe), .pinIn(pinIn), .pinPattern(pinPattern), .pinOverride(pinOverride),
      .qDriveEn(qDriveEn));
   sbt_jtag_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   task automatic check(input string what, input logic [108:0] seen, input logic [108:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic core_wait(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic load_ir(input logic [2:0] op);
      ctl.scan(1'b1, 3, {106'h0, op}, dout);
      check("ir capture", dout[2:0], 3'h1);
   endtask
   task automatic read_id();
      ctl.scan(1'b0, 32, '0, dout);
      check("id word", dout[31:0], {REV, DEV, VEND, 1'b1});
      check("tdo released", tdoOe, 1'b0);
   endtask
   task automatic pins(input logic ov, input logic en, input logic [107:0] pat);
      core_wait(8);
      check("override", pinOverride, ov);
      check("drive enable", qDriveEn, en);
      if (ov) check("pattern", pinPattern, pat);
   endtask
   task automatic t_reset_id();
      pins(1'b0, 1'b1, '0);
      ctl.go_reset();
      read_id();
   endtask
   task automatic t_bypass();
      load_ir(`SBT_OP_BYPASS);
      ctl.scan(1'b0, 8, 109'h0b5, dout);
      check("bypass", dout[7:0], 8'h6a);
      pins(1'b0, 1'b1, '0);
   endtask
   task automatic t_sample();
      @(negedge core_clk);
      pinIn = {12{9'h1a5}};
      core_wait(20);
      load_ir(`SBT_OP_SAMPLE);
      ctl.scan(1'b0, 109, {1'b0, ~pinIn}, dout);
      check("sample chain", dout, {1'b1, pinIn});
      pins(1'b0, 1'b1, '0);
   endtask
   task automatic t_extest();
      load_ir(`SBT_OP_EXTEST);
      pins(1'b1, 1'b0, ~pinIn);
      ctl.scan(1'b0, 109, {1'b1, pinIn}, dout);
      check("extest chain", dout, {1'b0, pinIn});
      pins(1'b1, 1'b1, pinIn);
   endtask
   task automatic t_highz();
      load_ir(`SBT_OP_SAMPLEZ);
      pins(1'b0, 1'b0, '0);
      ctl.scan(1'b0, 109, {1'b0, pinIn}, dout);
      check("highz chain", dout[107:0], pinIn);
   endtask
   task automatic t_tlr();
      ctl.go_reset();
      pins(1'b0, 1'b1, '0);
      read_id();
      load_ir(`SBT_OP_EXTEST);
      core_wait(8);
      check("preset enable", qDriveEn, 1'b1);
   endtask
   initial begin
      core_wait(8);
      arst_n = 1'b1;
      t_reset_id();
      t_bypass();
      t_sample();
      t_extest();
      t_highz();
      t_tlr();
      complete_run();
   end
   initial begin
      #200000;
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
